// ### rtl/change_flag_cell.sv
// sticky flag that latches a change or an edge of a status value
`timescale 1ns/10ps
`include "irq_flags_defs.svh"
module change_flag_cell #(
	parameter int WIDTH = 1,
	parameter logic [1:0] EDGE = `EDGE_ANY
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// watched status, already synchronised
	input wire logic [WIDTH-1:0] status,
	input wire logic armed,
	// clear request and flag
	input wire logic clr,
	output logic flag
);
	logic [WIDTH-1:0] prev_r;
	logic hit;

	// event detect by the configured kind
	always_comb begin
		case (EDGE)
			`EDGE_RISE: hit = status[0] & ~prev_r[0];
			`EDGE_FALL: hit = ~status[0] & prev_r[0];
			default: hit = (status != prev_r);
		endcase
	end

	// previous value follows the status every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= status;
		end
	end

	// set wins over clear so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else if (armed && hit) begin
			flag <= 1'b1;
		end else if (clr) begin
			flag <= 1'b0;
		end
	end
endmodule

// ### rtl/irq_flags_defs.svh
// constants for the thermal and charger-detect interrupt flag block
`ifndef IRQ_FLAGS_DEFS_SVH
`define IRQ_FLAGS_DEFS_SVH

// ----------------------------------------
// register indexes; byte address is four times the index
// ----------------------------------------
`define THERM_IDX 8'h0F
`define DETECT_IDX 8'h10
`define THERM_MASK_IDX 8'h20
`define DETECT_MASK_IDX 8'h21
`define LIVE_IDX 8'h22
`define IDX_ADDR(i) ({(i), 2'h0})
`define ADDR_W 10

// ----------------------------------------
// thermal flag register layout, bits 7..3 read zero
// ----------------------------------------
`define THERM_CUR_BIT 2
`define THERM_VLT_BIT 1
`define THERM_ZONE_BIT 0
`define THERM_USED 8'h07

// ----------------------------------------
// detect flag register layout, bits 1..0 read zero
// ----------------------------------------
`define DET_SUPPLY_BIT 7
`define DET_RUN_FALL_BIT 6
`define DET_RUN_RISE_BIT 5
`define DET_PREV_BIT 4
`define DET_TMO_BIT 3
`define DET_KIND_BIT 2
`define DETECT_USED 8'hFC

// ----------------------------------------
// status source widths and reset values
// ----------------------------------------
`define ZONE_W 3
`define KIND_W 2
`define STAT_W 12
`define FLAGS_RST 8'h00
`define MASK_RST 8'hFF

// ----------------------------------------
// flag cell edge kinds
// ----------------------------------------
`define EDGE_ANY 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2

`endif

// ### rtl/irq_flags_pkg.sv
// types for the thermal and charger-detect interrupt flag block
package irq_flags_pkg;
	// apb slave phase, one-hot
	typedef enum logic [1:0] {
		PH_IDLE = 2'h1,
		PH_ACCESS = 2'h2
	} apb_phase_t;
endpackage

// ### rtl/sync_two_ff.sv
// two flip-flop synchroniser for a bus of independent level inputs
`timescale 1ns/10ps
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels in and out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ### rtl/therm_detect_irq.sv
// thermal and charger-detect clear-on-read interrupt flags with apb access
// Contract
// - thermal flag register at index 0x0F, top five bits unused read zero.
// - current-reduction flag sets when its status changes since last read.
// - reading a flag clears it; zero means no change since last read.
// - voltage-reduction flag sets when its status changes since last read.
// - zone flag sets when any of the three zone bits changes.
// - charger-detect flag register at index 0x10.
// - supply-present flag sets when supply status changes.
// - detection-running has separate rise and fall edge flags, each read-cleared.
// - previous charger kind flag sets when that value changes.
// - contact timeout flag sets when timeout status changes.
// - charger kind flag sets when detected kind changes.
`timescale 1ns/10ps
`include "irq_flags_defs.svh"
module therm_detect_irq (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// status sources from the charger
	input wire logic thermal_current_reduce_state,
	input wire logic thermal_voltage_reduce_state,
	input wire logic [`ZONE_W-1:0] thermal_zone_state,
	input wire logic supply_present_state,
	input wire logic detect_running_state,
	input wire logic [`KIND_W-1:0] prev_charger_kind,
	input wire logic contact_timeout_state,
	input wire logic [`KIND_W-1:0] charger_kind,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// synchronised status and arming
	// ----------------------------------------
	logic [`STAT_W-1:0] stat_raw;
	logic [`STAT_W-1:0] stat_s;
	logic armed_r;
	logic cur_s, vlt_s, sup_s, run_s, tmo_s;
	logic [`ZONE_W-1:0] zone_s;
	logic [`KIND_W-1:0] prev_s, kind_s;

	assign stat_raw = {thermal_current_reduce_state, thermal_voltage_reduce_state,
		thermal_zone_state, supply_present_state, detect_running_state,
		prev_charger_kind, contact_timeout_state, charger_kind};
	assign {cur_s, vlt_s, zone_s, sup_s, run_s, prev_s, tmo_s, kind_s} = stat_s;

	sync_two_ff #(.WIDTH(`STAT_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(stat_raw),
		.sync_out(stat_s)
	);

	// flags arm once synchronised values have settled after reset
	logic [1:0] settle_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_r <= 2'h0;
			armed_r <= 1'b0;
		end else begin
			settle_r <= {settle_r[0], 1'b1};
			armed_r <= settle_r[1];
		end
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	irq_flags_pkg::apb_phase_t phase_r;
	logic setup, access, rd_acc, wr_acc, hit_any;
	logic [7:0] therm_flags, detect_flags, therm_mask_r, detect_mask_r, rd_val;
	logic [7:0] therm_clr, detect_clr;

	function automatic logic is_reg(input logic [`ADDR_W-1:0] a, input logic [7:0] idx);
		is_reg = (a == `IDX_ADDR(idx));
	endfunction

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign rd_acc = access & ~pwrite;
	assign wr_acc = access & pwrite;
	assign pready = 1'b1;
	assign hit_any = is_reg(paddr, `THERM_IDX) | is_reg(paddr, `DETECT_IDX) |
		is_reg(paddr, `THERM_MASK_IDX) | is_reg(paddr, `DETECT_MASK_IDX) |
		is_reg(paddr, `LIVE_IDX);
	assign pslverr = access & ~hit_any;

	// read mux, evaluated in the setup cycle
	always_comb begin
		rd_val = 8'h00;
		if (is_reg(paddr, `THERM_IDX)) begin
			rd_val = therm_flags & `THERM_USED;
		end else if (is_reg(paddr, `DETECT_IDX)) begin
			rd_val = detect_flags & `DETECT_USED;
		end else if (is_reg(paddr, `THERM_MASK_IDX)) begin
			rd_val = therm_mask_r;
		end else if (is_reg(paddr, `DETECT_MASK_IDX)) begin
			rd_val = detect_mask_r;
		end else if (is_reg(paddr, `LIVE_IDX)) begin
			rd_val = {sup_s, run_s, tmo_s, cur_s, vlt_s, zone_s};
		end
	end

	// phase tracker
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= irq_flags_pkg::PH_IDLE;
		end else begin
			case (phase_r)
				irq_flags_pkg::PH_IDLE: if (setup) phase_r <= irq_flags_pkg::PH_ACCESS;
				irq_flags_pkg::PH_ACCESS: if (!setup) phase_r <= irq_flags_pkg::PH_IDLE;
				default: phase_r <= irq_flags_pkg::PH_IDLE;
			endcase
		end
	end

	// read data captured at setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= {24'h00_0000, rd_val};
		end
	end

	// mask registers, set bit masks the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_mask_r <= `MASK_RST;
			detect_mask_r <= `MASK_RST;
		end else if (wr_acc) begin
			if (is_reg(paddr, `THERM_MASK_IDX)) therm_mask_r <= pwdata[7:0];
			if (is_reg(paddr, `DETECT_MASK_IDX)) detect_mask_r <= pwdata[7:0];
		end
	end

	// clear only bits returned by this read, or written as one
	always_comb begin
		therm_clr = 8'h00;
		detect_clr = 8'h00;
		if (rd_acc && is_reg(paddr, `THERM_IDX)) therm_clr = prdata[7:0];
		if (rd_acc && is_reg(paddr, `DETECT_IDX)) detect_clr = prdata[7:0];
		if (wr_acc && is_reg(paddr, `THERM_IDX)) therm_clr = pwdata[7:0];
		if (wr_acc && is_reg(paddr, `DETECT_IDX)) detect_clr = pwdata[7:0];
	end

	// ----------------------------------------
	// flag cells
	// ----------------------------------------
	assign therm_flags[7:3] = 5'h00;
	assign detect_flags[1:0] = 2'h0;

	// thermal current reduction
	change_flag_cell #(.WIDTH(1), .EDGE(`EDGE_ANY)) u_cur (
		.pclk(pclk), .presetn(presetn), .status(cur_s), .armed(armed_r),
		.clr(therm_clr[`THERM_CUR_BIT]), .flag(therm_flags[`THERM_CUR_BIT]));
	// thermal voltage reduction
	change_flag_cell #(.WIDTH(1), .EDGE(`EDGE_ANY)) u_vlt (
		.pclk(pclk), .presetn(presetn), .status(vlt_s), .armed(armed_r),
		.clr(therm_clr[`THERM_VLT_BIT]), .flag(therm_flags[`THERM_VLT_BIT]));
	// thermal zone, any of three bits
	change_flag_cell #(.WIDTH(`ZONE_W), .EDGE(`EDGE_ANY)) u_zone (
		.pclk(pclk), .presetn(presetn), .status(zone_s), .armed(armed_r),
		.clr(therm_clr[`THERM_ZONE_BIT]), .flag(therm_flags[`THERM_ZONE_BIT]));
	// supply present
	change_flag_cell #(.WIDTH(1), .EDGE(`EDGE_ANY)) u_sup (
		.pclk(pclk), .presetn(presetn), .status(sup_s), .armed(armed_r),
		.clr(detect_clr[`DET_SUPPLY_BIT]), .flag(detect_flags[`DET_SUPPLY_BIT]));
	// detection running, falling edge
	change_flag_cell #(.WIDTH(1), .EDGE(`EDGE_FALL)) u_fall (
		.pclk(pclk), .presetn(presetn), .status(run_s), .armed(armed_r),
		.clr(detect_clr[`DET_RUN_FALL_BIT]), .flag(detect_flags[`DET_RUN_FALL_BIT]));
	// detection running, rising edge
	change_flag_cell #(.WIDTH(1), .EDGE(`EDGE_RISE)) u_rise (
		.pclk(pclk), .presetn(presetn), .status(run_s), .armed(armed_r),
		.clr(detect_clr[`DET_RUN_RISE_BIT]), .flag(detect_flags[`DET_RUN_RISE_BIT]));
	// previous charger kind
	change_flag_cell #(.WIDTH(`KIND_W), .EDGE(`EDGE_ANY)) u_prev (
		.pclk(pclk), .presetn(presetn), .status(prev_s), .armed(armed_r),
		.clr(detect_clr[`DET_PREV_BIT]), .flag(detect_flags[`DET_PREV_BIT]));
	// contact detect timeout
	change_flag_cell #(.WIDTH(1), .EDGE(`EDGE_ANY)) u_tmo (
		.pclk(pclk), .presetn(presetn), .status(tmo_s), .armed(armed_r),
		.clr(detect_clr[`DET_TMO_BIT]), .flag(detect_flags[`DET_TMO_BIT]));
	// detected charger kind
	change_flag_cell #(.WIDTH(`KIND_W), .EDGE(`EDGE_ANY)) u_kind (
		.pclk(pclk), .presetn(presetn), .status(kind_s), .armed(armed_r),
		.clr(detect_clr[`DET_KIND_BIT]), .flag(detect_flags[`DET_KIND_BIT]));

	// level interrupt from unmasked flags
	assign irq = |(therm_flags & ~therm_mask_r) | |(detect_flags & ~detect_mask_r);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence therm_read_s;
		setup && !pwrite && is_reg(paddr, `THERM_IDX) ##1 rd_acc;
	endsequence

	therm_top_zero_a: assert property (therm_read_s |-> prdata[7:3] == 5'h00)
		else $error("thermal register unused bits not zero");
	cur_change_a: assert property (armed_r && cur_s != $past(cur_s)
		|=> therm_flags[`THERM_CUR_BIT])
		else $error("current reduction change not flagged");
	read_clears_a: assert property (therm_read_s ##0 prdata[`THERM_VLT_BIT]
		&& $stable(vlt_s) |=> !therm_flags[`THERM_VLT_BIT])
		else $error("read did not clear voltage flag");
	vlt_change_a: assert property (armed_r && $changed(vlt_s)
		|=> therm_flags[`THERM_VLT_BIT])
		else $error("voltage reduction change not flagged");
	zone_change_a: assert property (armed_r && $changed(zone_s)
		|=> therm_flags[`THERM_ZONE_BIT])
		else $error("zone change not flagged");
	detect_top_a: assert property (setup && !pwrite && is_reg(paddr, `DETECT_IDX)
		|=> prdata[1:0] == 2'h0 && prdata[7:2] == $past(detect_flags[7:2]))
		else $error("detect register read value wrong");
	supply_change_a: assert property (armed_r && $changed(sup_s)
		|=> detect_flags[`DET_SUPPLY_BIT])
		else $error("supply change not flagged");
	run_edges_a: assert property (armed_r && $rose(run_s)
		|=> detect_flags[`DET_RUN_RISE_BIT] && $stable(detect_flags[`DET_RUN_FALL_BIT]))
		else $error("rising edge flag wrong");
	run_fall_a: assert property (armed_r && $fell(run_s)
		|=> detect_flags[`DET_RUN_FALL_BIT])
		else $error("falling edge flag not set");
	prev_change_a: assert property (armed_r && $changed(prev_s)
		|=> detect_flags[`DET_PREV_BIT])
		else $error("previous kind change not flagged");
	tmo_change_a: assert property (armed_r && $changed(tmo_s)
		|=> detect_flags[`DET_TMO_BIT])
		else $error("timeout change not flagged");
	kind_change_a: assert property (armed_r && $changed(kind_s)
		|=> detect_flags[`DET_KIND_BIT])
		else $error("charger kind change not flagged");
	set_wins_a: assert property (rd_acc && is_reg(paddr, `DETECT_IDX) && armed_r
		&& $changed(kind_s) |=> detect_flags[`DET_KIND_BIT])
		else $error("change lost during read");
	irq_level_a: assert property (irq == (|(therm_flags & ~therm_mask_r)
		|| |(detect_flags & ~detect_mask_r)))
		else $error("interrupt level mismatch");

	// detect register read followed by its access phase
	sequence detect_read_s;
		setup && !pwrite && is_reg(paddr, `DETECT_IDX) ##1 rd_acc;
	endsequence

	// mask register write in its access phase
	sequence tmask_write_s;
		wr_acc && is_reg(paddr, `THERM_MASK_IDX);
	endsequence

	// a returned supply flag with no new change is gone after the read
	detect_clears_a: assert property (detect_read_s ##0 prdata[`DET_SUPPLY_BIT]
		&& $stable(sup_s) |=> !detect_flags[`DET_SUPPLY_BIT])
		else $error("read did not clear supply flag");
	// a set flag holds until a clear reaches it
	flag_sticky_a: assert property (therm_flags[`THERM_CUR_BIT]
		&& !therm_clr[`THERM_CUR_BIT] |=> therm_flags[`THERM_CUR_BIT])
		else $error("current flag dropped without clear");
	// no change, no flag
	cur_quiet_a: assert property (!therm_flags[`THERM_CUR_BIT] && $stable(cur_s)
		|=> !therm_flags[`THERM_CUR_BIT])
		else $error("current flag set without change");
	kind_quiet_a: assert property (!detect_flags[`DET_KIND_BIT] && $stable(kind_s)
		|=> !detect_flags[`DET_KIND_BIT])
		else $error("kind flag set without change");
	// a rising edge never raises the falling edge flag
	fall_only_a: assert property (armed_r && $rose(run_s)
		&& !detect_flags[`DET_RUN_FALL_BIT] |=> !detect_flags[`DET_RUN_FALL_BIT])
		else $error("falling flag set on rising edge");
	// flags stay clear until the synchronisers have settled
	unarmed_a: assert property (!armed_r |-> therm_flags == `FLAGS_RST
		&& detect_flags == `FLAGS_RST)
		else $error("flag set before arming");
	// access phase only after a tracked setup
	access_phase_a: assert property (access |-> phase_r == irq_flags_pkg::PH_ACCESS)
		else $error("access without setup");
	// registers are one byte wide
	prdata_upper_a: assert property (prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	// mask write lands at the access edge
	mask_write_a: assert property (tmask_write_s |=> therm_mask_r == $past(pwdata[7:0]))
		else $error("thermal mask write lost");
endmodule

// ### tb/status_source_model.sv
// behavioural model of the charger status sources feeding the flag block
`timescale 1ns/10ps
module status_source_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bits to invert at the next edge, and the resulting levels
	input wire logic [11:0] flip,
	output logic [11:0] stat
);
	// levels change only just after a rising edge, like a real flop-driven source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= 12'h000;
		end else begin
			stat <= stat ^ flip;
		end
	end
endmodule

// ### tb/therm_detect_irq_tb.sv
// self-checking bench for the thermal and charger-detect flag block
`timescale 1ns/10ps
`include "irq_flags_defs.svh"
module therm_detect_irq_tb;
	typedef struct {logic [11:0] m; logic [7:0] t; logic [7:0] d;} row_t;
	localparam logic [9:0] TA = `IDX_ADDR(`THERM_IDX);
	localparam logic [9:0] DA = `IDX_ADDR(`DETECT_IDX);
	localparam logic [9:0] TM = `IDX_ADDR(`THERM_MASK_IDX);
	localparam logic [9:0] DM = `IDX_ADDR(`DETECT_MASK_IDX);
	localparam logic [9:0] LA = `IDX_ADDR(`LIVE_IDX);
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [`ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q, q2;
	logic [11:0] flip, stat;
	int n_errors, n_tests;
	int cyc = 0;
	// one status bit per row; run toggles twice for rise then fall
	row_t rows [12] = '{'{12'h001, 8'h04, 8'h00}, '{12'h002, 8'h02, 8'h00},
		'{12'h004, 8'h01, 8'h00}, '{12'h010, 8'h01, 8'h00}, '{12'h020, 8'h00, 8'h80},
		'{12'h040, 8'h00, 8'h20}, '{12'h040, 8'h00, 8'h40}, '{12'h080, 8'h00, 8'h10},
		'{12'h100, 8'h00, 8'h10}, '{12'h200, 8'h00, 8'h08}, '{12'h400, 8'h00, 8'h04},
		'{12'h800, 8'h00, 8'h04}};
	// ----------------------------------------
	// design and status sources
	// ----------------------------------------
	therm_detect_irq i_therm_detect_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.thermal_current_reduce_state(stat[0]), .thermal_voltage_reduce_state(stat[1]),
		.thermal_zone_state(stat[4:2]), .supply_present_state(stat[5]),
		.detect_running_state(stat[6]), .prev_charger_kind(stat[8:7]),
		.contact_timeout_state(stat[9]), .charger_kind(stat[11:10]), .irq(irq));
	status_source_model i_status_source_model (.pclk(pclk), .presetn(presetn),
		.flip(flip), .stat(stat));
	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// hang guard well above the expected run length
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic se);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) n_errors++;
		r = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic toggle(input logic [11:0] m, input int wt);
		@(posedge pclk);
		flip <= m;
		@(posedge pclk);
		flip <= 12'h000;
		repeat (wt) @(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, flip, n_errors, n_tests} = '0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		// reset values of flags, the thermal mask and irq
		check("irq rst", 32'h0, {31'h0, irq});
		apb(1'b0, TA, 32'h0, q, err);
		check("therm rst", 32'h0, q);
		apb(1'b0, DA, 32'h0, q, err);
		check("detect rst", 32'h0, q);
		apb(1'b0, TM, 32'h0, q, err);
		check("tmask rst", 32'hFF, q);
		$display("test reset done");
		// each source sets only its own flag, read clears it
		foreach (rows[i]) begin
			toggle(rows[i].m, 5);
			apb(1'b0, TA, 32'h0, q, err);
			check("therm flag", {24'h0, rows[i].t}, q);
			apb(1'b0, DA, 32'h0, q, err);
			check("detect flag", {24'h0, rows[i].d}, q);
			apb(1'b0, TA, 32'h0, q, err);
			apb(1'b0, DA, 32'h0, q2, err);
			check("reread", 32'h0, q | q2);
		end
		$display("test table done");
		// live status reflects the sources and ignores writes
		apb(1'b1, LA, 32'hFF, q, err);
		apb(1'b0, LA, 32'h0, q, err);
		check("live", {24'h0, stat[5], stat[6], stat[9], stat[0], stat[1], stat[4:2]}, q);
		// unmapped address is refused
		apb(1'b0, `IDX_ADDR(8'h30), 32'h0, q, err);
		check("unmapped err", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, q);
		check("pready", 32'h1, {31'h0, pready});
		// change and back still leaves the flag set
		toggle(12'h001, 2);
		toggle(12'h001, 5);
		apb(1'b0, TA, 32'h0, q, err);
		check("glitch", 32'h04, q);
		// change landing near the clearing read is never lost
		for (int k = 0; k < 6; k++) begin
			toggle(12'h002, k);
			apb(1'b0, TA, 32'h0, q, err);
			repeat (5) @(posedge pclk);
			apb(1'b0, TA, 32'h0, q2, err);
			check("race", 32'h02, (q | q2) & 32'h02);
		end
		$display("test race done");
		// irq follows unmasked flags, masking and write-one clear
		apb(1'b1, TM, 32'h00, q, err);
		toggle(12'h001, 5);
		check("irq set", 32'h1, {31'h0, irq});
		apb(1'b1, TM, 32'hFF, q, err);
		@(posedge pclk);
		check("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, TM, 32'h00, q, err);
		@(posedge pclk);
		check("irq unmask", 32'h1, {31'h0, irq});
		apb(1'b1, TA, 32'h04, q, err);
		@(posedge pclk);
		check("irq w1c", 32'h0, {31'h0, irq});
		apb(1'b1, DM, 32'h00, q, err);
		toggle(12'h020, 5);
		check("irq detect", 32'h1, {31'h0, irq});
		// second reset mid-run clears flags and irq
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		check("irq rst2", 32'h0, {31'h0, irq});
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, DA, 32'h0, q, err);
		check("detect rst2", 32'h0, q);
		$display("test irq and reset done");
		give_verdict();
	end
endmodule
